// >>> fpps_pkg.sv
// package: constants and types of the flash page program sequencer
`default_nettype none

package fpps_pkg;
    // ------------------------------------------------------------
    // bus and page geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;
    localparam int WORD_W = 128;
    localparam int PAGE_WORDS = 8;
    localparam int PAGE_DW = 32;
    localparam int IDX_W = 3;
    localparam int CNT_W = 4;
    localparam int DWI_W = 5;
    localparam int PAGE_W = 6;
    localparam int REGION_W = 3;
    localparam int REGION_N = 8;
    localparam int ARR_AW = 9;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_MODE = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_CMD = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_MASK = 12'h00C;
    localparam logic [ADDR_W-1:0] OFS_LOCK = 12'h010;
    localparam logic [ADDR_W-1:0] OFS_LATCH = 12'h100;
    localparam logic [ADDR_W-1:0] LATCH_SPAN = 12'h07F;

    // ------------------------------------------------------------
    // fields
    // ------------------------------------------------------------
    localparam int MODE_RDY_IE = 0;
    localparam int ST_READY = 0;
    localparam int EV_LSB = 1;
    localparam int EV_W = 4;
    localparam int EV_DONE = 0;
    localparam int EV_CMD = 1;
    localparam int EV_LOCK = 2;
    localparam int EV_FLASH = 3;
    localparam int CMD_LSB = 0;
    localparam int CMD_W = 8;
    localparam int ARG_LSB = 8;
    localparam int KEY_LSB = 24;
    localparam int KEY_W = 8;
    localparam logic [KEY_W-1:0] KEY_VALUE = 8'hC3;
    localparam logic [CMD_W-1:0] CMD_WP = 8'h01;
    localparam logic [CMD_W-1:0] CMD_LOCK = 8'h08;
    localparam logic [CMD_W-1:0] CMD_UNLOCK = 8'h09;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 50;
    localparam int PGM_STD_NS = 3000;
    localparam int PGM_OPT_NS = 1000;
    localparam int PGM_STD_CYC = (PGM_STD_NS + CLK_NS - 1) / CLK_NS;
    localparam int PGM_OPT_CYC = (PGM_OPT_NS + CLK_NS - 1) / CLK_NS;
    localparam int TMR_W = 8;

    typedef enum logic [2:0] {S_IDLE, S_PROG, S_WAIT, S_VREQ, S_VWAIT, S_VCHK, S_DONE} fpps_state_t;
endpackage

`default_nettype wire

// >>> fpps_sequencer.sv
// flash page program sequencer with AXI4-Lite register slave
// Contract
// - ready flag rises when programming finishes
// - ready interrupt fires when enabled and ready rises
// - bad key on command write sets command error
// - locked page gives lock error, no programming
// - verify after programming, failure sets flash error
// - one page per operation only
// - full or partial page programming supported
// - latch zeros are cleared in the array
// - array access blocked while programming; host stays off
// - count 128-bit words to program, choose procedure
// - single word uses shortened program time
// - two or more words use standard procedure
//
// The register offsets and the AXI4-Lite slave port were decided locally.
`default_nettype none

module fpps_sequencer (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // axi4-lite write address
    input wire logic [fpps_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output var logic awready,
    // axi4-lite write data
    input wire logic [fpps_pkg::DATA_W-1:0] wdata,
    input wire logic [fpps_pkg::STRB_W-1:0] wstrb,
    input wire logic wvalid,
    output var logic wready,
    // axi4-lite write response
    output var logic [1:0] bresp,
    output var logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [fpps_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output var logic arready,
    output var logic [fpps_pkg::DATA_W-1:0] rdata,
    output var logic [1:0] rresp,
    output var logic rvalid,
    input wire logic rready,
    // flash array side
    output var logic arrPgmStrobe,
    output var logic arrRdStrobe,
    output var logic [fpps_pkg::ARR_AW-1:0] arrAddr,
    output var logic [fpps_pkg::WORD_W-1:0] arrWrData,
    input wire logic [fpps_pkg::WORD_W-1:0] arrRdData,
    output var logic arrAccessBlock,
    // status
    output var logic flashReadyFlag,
    output var logic irq
);
    import fpps_pkg::*;

    localparam int OPT_DLY = PGM_OPT_CYC + 1;
    localparam int STD_DLY = PGM_STD_CYC + 1;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic [DATA_W-1:0] mergeStrb(input logic [DATA_W-1:0] oldV,
                                                    input logic [DATA_W-1:0] newV,
                                                    input logic [STRB_W-1:0] strb);
        logic [DATA_W-1:0] v;
        v = oldV;
        for (int b = 0; b < STRB_W; b++) begin
            if (strb[b]) begin
                v[8*b +: 8] = newV[8*b +: 8];
            end
        end
        return v;
    endfunction

    function automatic logic isLatch(input logic [ADDR_W-1:0] a);
        return (a & ~LATCH_SPAN) == OFS_LATCH;
    endfunction

    function automatic logic isMapped(input logic [ADDR_W-1:0] a);
        return isLatch(a) || a == OFS_MODE || a == OFS_CMD || a == OFS_STATUS
            || a == OFS_MASK || a == OFS_LOCK;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [DATA_W-1:0] latch [PAGE_DW];
    logic [WORD_W-1:0] pageWord [PAGE_WORDS];
    logic [PAGE_WORDS-1:0] wordBlank;
    logic [ADDR_W-1:0] awAddrReg;
    logic [DATA_W-1:0] wDataReg;
    logic [STRB_W-1:0] wStrbReg;
    fpps_state_t stateReg;
    logic optReg;
    logic [IDX_W-1:0] idxReg;
    logic [PAGE_W-1:0] pageReg;
    logic [TMR_W-1:0] timerReg;
    logic modeReg;
    logic [EV_W-1:1] maskReg;
    logic [REGION_N-1:0] lockReg;
    logic [EV_W-1:0] evtReg;
    logic [EV_W-1:0] evtNext;
    logic [EV_W-1:0] evtSet;
    logic [EV_W-1:0] evtClr;
    logic [CNT_W-1:0] nonBlankCnt;
    logic [IDX_W-1:0] firstIdx;
    logic [DATA_W-1:0] rdVal;
    logic wrPulse;
    logic cmdWr;
    logic keyOk;
    logic [DATA_W-1:0] cmdWord;
    logic [CMD_W-1:0] cmdCode;
    logic [PAGE_W-1:0] cmdPage;
    logic [REGION_W-1:0] cmdRegion;
    logic cmdBad;
    logic wpLocked;
    logic wpStart;
    logic mismatch;

    // ------------------------------------------------------------
    // latch words and word count
    // ------------------------------------------------------------
    for (genvar i = 0; i < PAGE_WORDS; i++) begin : g_word
        assign pageWord[i] = {latch[4*i+3], latch[4*i+2], latch[4*i+1], latch[4*i]};
        assign wordBlank[i] = &pageWord[i];
    end

    always_comb begin
        nonBlankCnt = '0;
        firstIdx = '0;
        for (int i = PAGE_WORDS - 1; i >= 0; i--) begin
            if (!wordBlank[i]) begin
                nonBlankCnt = nonBlankCnt + 1'b1;
                firstIdx = IDX_W'(i);
            end
        end
    end

    // ------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------
    assign wrPulse = !awready && !wready && !bvalid;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            awAddrReg <= '0;
            wDataReg <= '0;
            wStrbReg <= '0;
        end else begin
            if (awvalid && awready) begin
                awAddrReg <= awaddr;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                wDataReg <= wdata;
                wStrbReg <= wstrb;
                wready <= 1'b0;
            end
            if (wrPulse) begin
                bvalid <= 1'b1;
                bresp <= isMapped(awAddrReg) ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    always_comb begin
        rdVal = '0;
        if (isLatch(araddr)) begin
            rdVal = latch[araddr[DWI_W+1:2]];
        end else begin
            case (araddr)
                OFS_MODE: rdVal[MODE_RDY_IE] = modeReg;
                OFS_STATUS: rdVal[EV_LSB +: EV_W] = evtReg;
                OFS_MASK: rdVal[EV_LSB+1 +: EV_W-1] = maskReg;
                OFS_LOCK: rdVal[REGION_N-1:0] = lockReg;
                default: rdVal = '0;
            endcase
            if (araddr == OFS_STATUS) begin
                rdVal[ST_READY] = flashReadyFlag;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else begin
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                rdata <= rdVal;
                rresp <= isMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
            end
            if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    assign cmdWord = mergeStrb('0, wDataReg, wStrbReg);
    assign cmdCode = cmdWord[CMD_LSB +: CMD_W];
    assign cmdPage = cmdWord[ARG_LSB +: PAGE_W];
    assign cmdRegion = cmdPage[PAGE_W-1 -: REGION_W];
    assign cmdWr = wrPulse && awAddrReg == OFS_CMD;
    assign keyOk = cmdWord[KEY_LSB +: KEY_W] == KEY_VALUE;
    // bad key is reported even while busy; valid commands are dropped unless ready
    assign cmdBad = cmdWr && (!keyOk || !(cmdCode == CMD_WP || cmdCode == CMD_LOCK
        || cmdCode == CMD_UNLOCK));
    assign wpLocked = cmdWr && keyOk && flashReadyFlag && cmdCode == CMD_WP && lockReg[cmdRegion];
    assign wpStart = cmdWr && keyOk && flashReadyFlag && cmdCode == CMD_WP && !lockReg[cmdRegion];
    assign mismatch = |(~pageWord[idxReg] & arrRdData);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lockReg <= '0;
        end else if (cmdWr && keyOk && flashReadyFlag) begin
            if (cmdCode == CMD_LOCK) begin
                lockReg[cmdRegion] <= 1'b1;
            end else if (cmdCode == CMD_UNLOCK) begin
                lockReg[cmdRegion] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // program sequencer
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stateReg <= S_IDLE;
            optReg <= 1'b0;
            idxReg <= '0;
            pageReg <= '0;
            timerReg <= '0;
            flashReadyFlag <= 1'b1;
            arrAccessBlock <= 1'b0;
            arrPgmStrobe <= 1'b0;
            arrRdStrobe <= 1'b0;
            arrAddr <= '0;
            arrWrData <= '0;
        end else begin
            arrPgmStrobe <= 1'b0;
            arrRdStrobe <= 1'b0;
            case (stateReg)
                S_IDLE: begin
                    if (wpStart) begin
                        optReg <= nonBlankCnt == CNT_W'(1);
                        idxReg <= nonBlankCnt == CNT_W'(1) ? firstIdx : '0;
                        pageReg <= cmdPage;
                        flashReadyFlag <= 1'b0;
                        arrAccessBlock <= 1'b1;
                        stateReg <= S_PROG;
                    end
                end
                S_PROG: begin
                    arrPgmStrobe <= 1'b1;
                    arrAddr <= {pageReg, idxReg};
                    arrWrData <= pageWord[idxReg];
                    timerReg <= optReg ? TMR_W'(PGM_OPT_CYC) : TMR_W'(PGM_STD_CYC);
                    stateReg <= S_WAIT;
                end
                S_WAIT: begin
                    if (timerReg == TMR_W'(1)) begin
                        stateReg <= S_VREQ;
                    end else begin
                        timerReg <= timerReg - 1'b1;
                    end
                end
                S_VREQ: begin
                    arrRdStrobe <= 1'b1;
                    stateReg <= S_VWAIT;
                end
                S_VWAIT: stateReg <= S_VCHK;
                S_VCHK: begin
                    // standard procedure walks every word of the page
                    if (optReg || idxReg == IDX_W'(PAGE_WORDS - 1)) begin
                        stateReg <= S_DONE;
                    end else begin
                        idxReg <= idxReg + 1'b1;
                        stateReg <= S_PROG;
                    end
                end
                S_DONE: begin
                    flashReadyFlag <= 1'b1;
                    arrAccessBlock <= 1'b0;
                    stateReg <= S_IDLE;
                end
                default: stateReg <= S_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // latch buffer
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < PAGE_DW; i++) begin
                latch[i] <= '1;
            end
        end else if (stateReg == S_DONE) begin
            // back to erased pattern so the next page starts clean
            for (int i = 0; i < PAGE_DW; i++) begin
                latch[i] <= '1;
            end
        end else if (wrPulse && isLatch(awAddrReg) && flashReadyFlag) begin
            latch[awAddrReg[DWI_W+1:2]] <= mergeStrb(latch[awAddrReg[DWI_W+1:2]], wDataReg, wStrbReg);
        end
    end

    // ------------------------------------------------------------
    // control registers, events and interrupt
    // ------------------------------------------------------------
    always_comb begin
        evtSet = '0;
        evtSet[EV_DONE] = stateReg == S_DONE;
        evtSet[EV_CMD] = cmdBad;
        evtSet[EV_LOCK] = wpLocked;
        evtSet[EV_FLASH] = stateReg == S_VCHK && mismatch;
        evtClr = '0;
        if (wrPulse && awAddrReg == OFS_STATUS) begin
            evtClr = cmdWord[EV_LSB +: EV_W];
        end
        evtNext = (evtReg & ~evtClr) | evtSet; // set wins over clear
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            modeReg <= 1'b0;
            maskReg <= '0;
            evtReg <= '0;
            irq <= 1'b0;
        end else begin
            evtReg <= evtNext;
            irq <= |(evtNext & {maskReg, modeReg});
            if (wrPulse && awAddrReg == OFS_MODE) begin
                modeReg <= cmdWord[MODE_RDY_IE];
            end
            if (wrPulse && awAddrReg == OFS_MASK) begin
                maskReg <= cmdWord[EV_LSB+1 +: EV_W-1];
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_ready_after_done: assert property (stateReg == S_DONE |=> flashReadyFlag && evtReg[EV_DONE])
        else $error("ready did not rise after programming");
    a_irq_on_ready: assert property ($rose(flashReadyFlag) && $past(modeReg) |-> irq)
        else $error("ready interrupt missing");
    a_bad_key_flag: assert property (cmdWr && !keyOk |=> evtReg[EV_CMD])
        else $error("bad key not flagged");
    a_locked_no_prog: assert property (wpLocked |=> evtReg[EV_LOCK] && stateReg == S_IDLE)
        else $error("locked page was programmed");
    a_verify_fail: assert property (stateReg == S_VCHK && mismatch |=> evtReg[EV_FLASH])
        else $error("verify failure not flagged");
    a_one_page: assert property (arrPgmStrobe |-> arrAddr[ARR_AW-1 -: PAGE_W] == pageReg)
        else $error("program outside current page");
    a_clear_data: assert property (arrPgmStrobe |-> arrWrData == pageWord[idxReg])
        else $error("program data differs from latch");
    a_block_busy: assert property (!flashReadyFlag |-> arrAccessBlock)
        else $error("array not blocked while busy");
    a_opt_choice: assert property (wpStart && nonBlankCnt == CNT_W'(1) |=> optReg)
        else $error("single word not optimized");
    a_opt_time: assert property (arrPgmStrobe && optReg |-> ##OPT_DLY arrRdStrobe)
        else $error("short program time wrong");
    a_std_time: assert property (arrPgmStrobe && !optReg |-> ##STD_DLY arrRdStrobe)
        else $error("standard program time wrong");
    a_busy_ready_low: assert property (stateReg != S_IDLE |-> !flashReadyFlag)
        else $error("ready high while busy");

    c_opt_wp: cover property (wpStart && nonBlankCnt == CNT_W'(1));
    c_std_wp: cover property (wpStart && nonBlankCnt > CNT_W'(1));
    c_lock_err: cover property (wpLocked);
    c_verify_err: cover property (stateReg == S_VCHK && mismatch);
endmodule // fpps_sequencer

`default_nettype wire

// >>> fpps_flash_model.sv
// behavioural flash array on the far side of the page program sequencer
`default_nettype none

module fpps_flash_model (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // array port
    input wire logic arrPgmStrobe,
    input wire logic arrRdStrobe,
    input wire logic [fpps_pkg::ARR_AW-1:0] arrAddr,
    input wire logic [fpps_pkg::WORD_W-1:0] arrWrData,
    output var logic [fpps_pkg::WORD_W-1:0] arrRdData,
    // test hooks
    input wire logic failVerify,
    output var int pgmCount,
    output var int pgmGap
);
    timeunit 1ns;
    timeprecision 1ps;
    import fpps_pkg::*;

    logic [WORD_W-1:0] mem [0:(1<<ARR_AW)-1];
    logic [WORD_W-1:0] rdReg;
    logic rdValid;
    int gapCnt;

    // ----------------------------------------------------------------
    // array contents
    // ----------------------------------------------------------------
    initial begin
        for (int i = 0; i < (1 << ARR_AW); i++) begin
            mem[i] = '1;
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdReg <= '0;
            rdValid <= 1'b0;
            pgmCount <= 0;
            pgmGap <= 0;
            gapCnt <= 0;
        end else begin
            gapCnt <= gapCnt + 1;
            rdValid <= arrRdStrobe;
            if (arrPgmStrobe) begin
                // programming only clears bits, never sets them
                mem[arrAddr] <= mem[arrAddr] & arrWrData;
                pgmCount <= pgmCount + 1;
                gapCnt <= 1;
            end
            if (arrRdStrobe) begin
                // a stuck bit makes the verify read disagree
                rdReg <= mem[arrAddr] | {{(WORD_W-1){1'b0}}, failVerify};
                pgmGap <= gapCnt;
            end
        end
    end

    // data only valid in the cycle after the strobe; inverted otherwise
    assign arrRdData = rdValid ? rdReg : ~rdReg;
endmodule // fpps_flash_model

`default_nettype wire

// >>> tb_fpps_sequencer.sv
// testbench of the flash page program sequencer
`default_nettype none

module tb_fpps_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    import fpps_pkg::*;

    logic mclk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, arrPgmStrobe, arrRdStrobe;
    logic arrAccessBlock, flashReadyFlag, irq, failVerify;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata, rd;
    logic [STRB_W-1:0] wstrb;
    logic [1:0] bresp, rresp, rs;
    logic [ARR_AW-1:0] arrAddr;
    logic [WORD_W-1:0] arrWrData, arrRdData;
    int pgmCount, pgmGap, base;
    int mismatches = 0;
    int checks_done = 0;
    localparam logic [WORD_W-1:0] PAT_A = 128'hFFFF0000_F0F0F0F0_12345678_AAAAAAAA;
    localparam logic [WORD_W-1:0] PAT_B = 128'h00000000_7FFFFFFE_C3C3C3C3_5555AAAA;

    fpps_sequencer u_fpps_sequencer (.mclk(mclk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .arrPgmStrobe(arrPgmStrobe),
        .arrRdStrobe(arrRdStrobe), .arrAddr(arrAddr), .arrWrData(arrWrData), .arrRdData(arrRdData),
        .arrAccessBlock(arrAccessBlock), .flashReadyFlag(flashReadyFlag), .irq(irq));
    fpps_flash_model u_fpps_flash_model (.mclk(mclk), .rst_n(rst_n), .arrPgmStrobe(arrPgmStrobe),
        .arrRdStrobe(arrRdStrobe), .arrAddr(arrAddr), .arrWrData(arrWrData), .arrRdData(arrRdData),
        .failVerify(failVerify), .pgmCount(pgmCount), .pgmGap(pgmGap));

    // ----------------------------------------------------------------
    // bus tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      input logic [STRB_W-1:0] s = 4'hF);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        bready <= 1'b1;
        do @(posedge mclk); while (!bvalid);
        rs = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp,
                          input logic [1:0] expResp);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge mclk); while (!arready);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge mclk); while (!rvalid);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        check(what, rd, exp);
        check({what, " resp"}, rs, expResp);
    endtask

    task automatic fill(input int n, input logic [WORD_W-1:0] v);
        for (int j = 0; j < 4; j++) begin
            wr(OFS_LATCH + ADDR_W'(16 * n + 4 * j), v[32*j+:32]);
        end
    endtask

    task automatic cmd(input logic [7:0] key, input logic [5:0] page, input logic [7:0] code);
        wr(OFS_CMD, {key, 10'h000, page, code});
        check("cmd resp", rs, RESP_OKAY);
    endtask

    task automatic wait_ready();
        for (int i = 0; i < 2000 && flashReadyFlag !== 1'b1; i++) @(posedge mclk);
        check("ready after run", flashReadyFlag, 1'b1);
    endtask

    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // a hang must not outlive the handful of program runs
    initial begin
        #(20000 * 50);
        mismatches++;
        end_sim();
    end

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, failVerify} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        rst_n = 1'b0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rd_chk("status reset", OFS_STATUS, 32'h00000001, RESP_OKAY);
        rd_chk("unmapped", 12'h200, 32'h00000000, RESP_SLVERR);
        wr(12'h204, 32'hFFFFFFFF);
        check("unmapped write", rs, RESP_SLVERR);
        // single word: shortened run, second command while busy is dropped
        wr(OFS_MODE, 32'h00000001);
        fill(2, PAT_A);
        cmd(KEY_VALUE, 6'h05, CMD_WP);
        check("busy ready", flashReadyFlag, 1'b0);
        check("busy block", arrAccessBlock, 1'b1);
        cmd(KEY_VALUE, 6'h07, CMD_WP);
        wait_ready();
        check("opt pulses", pgmCount, 1);
        check("opt gap", pgmGap, PGM_OPT_CYC + 1);
        check("opt word", u_fpps_flash_model.mem[5*8+2], PAT_A);
        check("opt block", arrAccessBlock, 1'b0);
        check("done irq", irq, 1'b1);
        rd_chk("status done", OFS_STATUS, 32'h00000003, RESP_OKAY);
        wr(OFS_STATUS, 32'h00000002);
        check("irq cleared", irq, 1'b0);
        // two words: standard run over the whole page
        base = pgmCount;
        fill(0, PAT_B);
        fill(7, PAT_A);
        cmd(KEY_VALUE, 6'h06, CMD_WP);
        wait_ready();
        check("std pulses", pgmCount - base, PAGE_WORDS);
        check("std gap", pgmGap, PGM_STD_CYC + 1);
        check("std word0", u_fpps_flash_model.mem[6*8+0], PAT_B);
        check("std word7", u_fpps_flash_model.mem[6*8+7], PAT_A);
        check("std word3", u_fpps_flash_model.mem[6*8+3], {WORD_W{1'b1}});
        // one byte in its own 128-bit word, written through a single lane
        wr(OFS_LATCH + 12'h040, 32'h000000A5, 4'h1);
        cmd(KEY_VALUE, 6'h0A, CMD_WP);
        wait_ready();
        check("byte word", u_fpps_flash_model.mem[10*8+4], {{120{1'b1}}, 8'hA5});
        wr(OFS_STATUS, 32'h00000002);
        // bad key and unknown code both report a command error
        wr(OFS_MASK, 32'h00000004);
        cmd(8'h00, 6'h01, CMD_WP);
        check("cmd err irq", irq, 1'b1);
        rd_chk("status key", OFS_STATUS, 32'h00000005, RESP_OKAY);
        wr(OFS_STATUS, 32'h00000004);
        cmd(KEY_VALUE, 6'h01, 8'h7E);
        rd_chk("status code", OFS_STATUS, 32'h00000005, RESP_OKAY);
        wr(OFS_STATUS, 32'h00000004);
        // locked region refuses the page
        base = pgmCount;
        cmd(KEY_VALUE, 6'h08, CMD_LOCK);
        rd_chk("lock bits", OFS_LOCK, 32'h00000002, RESP_OKAY);
        fill(1, PAT_B);
        cmd(KEY_VALUE, 6'h08, CMD_WP);
        repeat (4) @(posedge mclk);
        check("lock ready", flashReadyFlag, 1'b1);
        check("lock pulses", pgmCount, base);
        rd_chk("status lock", OFS_STATUS, 32'h00000009, RESP_OKAY);
        wr(OFS_STATUS, 32'h00000008);
        cmd(KEY_VALUE, 6'h08, CMD_UNLOCK);
        rd_chk("unlock bits", OFS_LOCK, 32'h00000000, RESP_OKAY);
        // verify failure raises the flash error
        wr(OFS_MASK, 32'h00000010);
        wr(OFS_MODE, 32'h00000000);
        failVerify <= 1'b1;
        fill(1, PAT_A);
        cmd(KEY_VALUE, 6'h09, CMD_WP);
        wait_ready();
        failVerify <= 1'b0;
        check("flash err irq", irq, 1'b1);
        rd_chk("status verify", OFS_STATUS, 32'h00000013, RESP_OKAY);
        end_sim();
    end
endmodule // tb_fpps_sequencer

`default_nettype wire
